/* File: rtl/ccu_pkg.sv */
package ccu_pkg;

    // ========================================================================
    // register map (byte-wide registers on a small plain port)
    // ========================================================================
    localparam int unsigned ADDR_W = 3;
    localparam int unsigned DATA_W = 8;

    localparam logic [ADDR_W-1:0] ADR_CTRL   = 3'h0; // unit_control_reg
    localparam logic [ADDR_W-1:0] ADR_VAL_LO = 3'h1; // value_pair_low
    localparam logic [ADDR_W-1:0] ADR_VAL_HI = 3'h2; // value_pair_high
    localparam logic [ADDR_W-1:0] ADR_FLAG   = 3'h3; // event_flag_reg
    localparam logic [ADDR_W-1:0] ADR_STATUS = 3'h4; // live unit state, read only

    // ========================================================================
    // field positions and reset values
    // ========================================================================
    localparam int unsigned CTRL_MODE_LSB = 0;
    localparam int unsigned CTRL_MODE_MSB = 3;
    localparam int unsigned CTRL_DUTY_LSB = 4;
    localparam int unsigned CTRL_DUTY_MSB = 5;
    localparam int unsigned FLAG_BIT      = 0;
    localparam int unsigned ST_MATCH_BIT  = 0;
    localparam int unsigned ST_PEND_BIT   = 1;
    localparam int unsigned ST_PINO_BIT   = 2;
    localparam int unsigned ST_PINI_BIT   = 3;

    localparam logic [DATA_W-1:0] CTRL_ZERO = 8'h00;
    localparam logic [DATA_W-1:0] REG_RST   = 8'h00;
    localparam logic [1:0]        DUTY_RST  = 2'h0;

    // ========================================================================
    // unit_mode_select encodings
    // ========================================================================
    localparam logic [3:0] MODE_OFF        = 4'h0;
    localparam logic [3:0] MODE_CMP_TOGGLE = 4'h2;
    localparam logic [3:0] MODE_CAP_FALL   = 4'h4;
    localparam logic [3:0] MODE_CAP_RISE   = 4'h5;
    localparam logic [3:0] MODE_CAP_RISE4  = 4'h6;
    localparam logic [3:0] MODE_CAP_RISE16 = 4'h7;
    localparam logic [3:0] MODE_CMP_SET    = 4'h8;
    localparam logic [3:0] MODE_CMP_CLR    = 4'h9;
    localparam logic [3:0] MODE_CMP_SWEVT  = 4'hA;
    localparam logic [3:0] MODE_CMP_TRIG   = 4'hB;
    localparam logic [1:0] MODE_PWM_TOP    = 2'h3; // any 11xx selects PWM

    // prescaler terminal counts (edges per capture minus one)
    localparam logic [3:0] PSC_LAST_1  = 4'h0;
    localparam logic [3:0] PSC_LAST_4  = 4'h3;
    localparam logic [3:0] PSC_LAST_16 = 4'hF;
    localparam logic [3:0] PSC_ZERO    = 4'h0;
    localparam logic [3:0] PSC_ONE     = 4'h1;

endpackage

/* File: rtl/ccu_prescale.sv */
`timescale 1ns/1ps
module ccu_prescale
    import ccu_pkg::*;
(
    input  wire logic  clock_i,
    input  wire logic  reset_i,
    ccu_psc_if.psc     psc
);

    logic [3:0] cnt_r;

    // ========================================================================
    // event counter
    // ========================================================================
    // a change of division alone never clears the count, so a stale count may
    // fire early; software is expected to switch the unit off in between
    always_ff @(posedge clock_i) begin
        if (reset_i || psc.clr) begin
            cnt_r <= PSC_ZERO;
        end else if (psc.edge_seen) begin
            if (cnt_r >= psc.last) begin
                cnt_r <= PSC_ZERO;
            end else begin
                cnt_r <= cnt_r + PSC_ONE;
            end
        end
    end

    assign psc.fire  = psc.edge_seen && !psc.clr && (cnt_r >= psc.last);
    assign psc.count = cnt_r;

    a_psc_cleared: assert property (@(posedge clock_i) disable iff (reset_i)
        psc.clr |=> (cnt_r == PSC_ZERO))
        else $error("prescaler not cleared");

endmodule // ccu_prescale

/* File: rtl/ccu_psc_if.sv */
`timescale 1ns/1ps
// carries edge events and the terminal count to the capture prescaler
interface ccu_psc_if;
    logic       edge_seen;
    logic       clr;
    logic [3:0] last;
    logic       fire;
    logic [3:0] count;

    modport unit (output edge_seen, output clr, output last, input fire, input count);
    modport psc  (input edge_seen, input clr, input last, output fire, output count);
endinterface

/* File: rtl/ccu_unit.sv */
`timescale 1ns/1ps
module ccu_unit
    import ccu_pkg::*;
(
    input  wire logic              clock_i,
    input  wire logic              reset_i,
    // register port
    input  wire logic [ADDR_W-1:0] addr_i,
    input  wire logic [DATA_W-1:0] wdata_i,
    input  wire logic              wr_i,
    input  wire logic              rd_i,
    output logic      [DATA_W-1:0] rdata_o,
    // unit pin
    input  wire logic              pin_in_i,
    output logic                   pin_out_o,
    output logic                   pin_oe_o,
    // counter A link
    input  wire logic [15:0]       count_a_i,
    input  wire logic              count_a_tick_i,
    input  wire logic              count_a_ext_i,
    output logic                   count_a_reset_o,
    // converter link
    input  wire logic              adc_enabled_i,
    output logic                   adc_trigger_o,
    // counter B time base for PWM
    input  wire logic [9:0]        pwm_base_i,
    input  wire logic              period_match_i,
    // system state
    input  wire logic              sleep_i,
    output logic                   unit_event_flag_o
);

    // ========================================================================
    // declarations
    // ========================================================================
    logic [3:0]  mode_r;
    logic [1:0]  duty_lsb_r;
    logic [7:0]  val_lo_r;
    logic [7:0]  val_hi_r;
    logic [1:0]  duty_latch_r;
    logic        flag_r;
    logic        flag_nxt;
    logic        pin_prev_r;
    logic [15:0] count_a_r;
    logic        tick_r;
    logic        match_r;
    logic        trig_pend_r;
    logic        cmp_latch_r;
    logic        pwm_r;

    logic        wr_ctrl;
    logic        wr_zero;
    logic        is_cap;
    logic        is_cmp;
    logic        is_pwm;
    logic        pin_owned;
    logic        rise;
    logic        fall;
    logic        cap_ok;
    logic        match;
    logic        hit;
    logic        cap_fire;
    logic        flag_clr;

    ccu_psc_if psc_if ();

    // ========================================================================
    // mode decode
    // ========================================================================
    assign wr_ctrl = wr_i && (addr_i == ADR_CTRL);
    assign wr_zero = wr_ctrl && (wdata_i == CTRL_ZERO);
    assign is_cap  = (mode_r == MODE_CAP_FALL) || (mode_r == MODE_CAP_RISE)
                  || (mode_r == MODE_CAP_RISE4) || (mode_r == MODE_CAP_RISE16);
    assign is_cmp  = (mode_r == MODE_CMP_TOGGLE) || (mode_r == MODE_CMP_SET)
                  || (mode_r == MODE_CMP_CLR) || (mode_r == MODE_CMP_SWEVT)
                  || (mode_r == MODE_CMP_TRIG);
    assign is_pwm  = (mode_r[3:2] == MODE_PWM_TOP);
    // software-event and trigger modes leave the pin alone
    assign pin_owned = (mode_r == MODE_CMP_TOGGLE) || (mode_r == MODE_CMP_SET)
                    || (mode_r == MODE_CMP_CLR) || is_pwm;

    // ========================================================================
    // control register
    // ========================================================================
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            mode_r     <= MODE_OFF;
            duty_lsb_r <= DUTY_RST;
        end else if (wr_ctrl) begin
            mode_r     <= wdata_i[CTRL_MODE_MSB:CTRL_MODE_LSB];
            duty_lsb_r <= wdata_i[CTRL_DUTY_MSB:CTRL_DUTY_LSB];
        end
    end

    // ========================================================================
    // counter A sampling
    // ========================================================================
    // the timer lives elsewhere; one register stage keeps compare and
    // capture on the system clock. with the instruction clock in sleep the
    // count is frozen here too, so compare resumes from the same value
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            count_a_r <= {8'h00, 8'h00};
            tick_r    <= 1'b0;
        end else if (sleep_i && !count_a_ext_i) begin
            tick_r    <= 1'b0;
        end else begin
            count_a_r <= count_a_i;
            tick_r    <= count_a_tick_i;
        end
    end

    // ========================================================================
    // capture path
    // ========================================================================
    // pin input is taken as synchronous; a one-flop history finds edges
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            pin_prev_r <= 1'b0;
        end else begin
            pin_prev_r <= pin_in_i;
        end
    end

    assign rise   = pin_in_i && !pin_prev_r;
    assign fall   = !pin_in_i && pin_prev_r;
    // in sleep only an externally clocked counter can be captured
    assign cap_ok = is_cap && (!sleep_i || count_a_ext_i);

    // prescaler sees falling edges in mode 0100, rising edges otherwise
    assign psc_if.edge_seen = cap_ok && ((mode_r == MODE_CAP_FALL) ? fall : rise);
    assign psc_if.clr       = !is_cap;

    always_comb begin
        case (mode_r)
            MODE_CAP_RISE4:  psc_if.last = PSC_LAST_4;
            MODE_CAP_RISE16: psc_if.last = PSC_LAST_16;
            default:         psc_if.last = PSC_LAST_1;
        endcase
    end

    ccu_prescale u_prescale (
        .clock_i (clock_i),
        .reset_i (reset_i),
        .psc     (psc_if.psc)
    );

    assign cap_fire = psc_if.fire;

    // ========================================================================
    // value pair
    // ========================================================================
    // a capture beats a software write in the same cycle; in PWM the high
    // byte is the duty shadow and ignores software
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            val_lo_r <= REG_RST;
            val_hi_r <= REG_RST;
        end else if (cap_fire) begin
            val_lo_r <= count_a_r[7:0];
            val_hi_r <= count_a_r[15:8];
        end else begin
            if (wr_i && (addr_i == ADR_VAL_LO)) begin
                val_lo_r <= wdata_i;
            end
            if (is_pwm && period_match_i) begin
                val_hi_r <= val_lo_r;
            end else if (wr_i && (addr_i == ADR_VAL_HI) && !is_pwm) begin
                val_hi_r <= wdata_i;
            end
        end
    end

    // ========================================================================
    // compare path
    // ========================================================================
    // the oscillator stops in sleep, so compare is simply held off then
    assign match = is_cmp && !sleep_i && ({val_hi_r, val_lo_r} == count_a_r);
    assign hit   = match && !match_r; // one event per match, however long it stands

    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            match_r <= 1'b0;
        end else begin
            match_r <= match;
        end
    end

    // compare output latch, separate from any port data latch
    always_ff @(posedge clock_i) begin
        if (reset_i || wr_zero) begin
            cmp_latch_r <= 1'b0;
        end else if (hit) begin
            case (mode_r)
                MODE_CMP_TOGGLE: cmp_latch_r <= !cmp_latch_r;
                MODE_CMP_SET:    cmp_latch_r <= 1'b1;
                MODE_CMP_CLR:    cmp_latch_r <= 1'b0;
                default:         cmp_latch_r <= cmp_latch_r;
            endcase
        end
    end

    // ========================================================================
    // auto-conversion trigger
    // ========================================================================
    // the trigger is immediate; the counter reset waits for the next counter
    // clock edge and is dropped if the match goes away first. the reset
    // request is its own strobe, never an overflow, so the overflow flag in
    // the timer stays untouched
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            adc_trigger_o   <= 1'b0;
            trig_pend_r     <= 1'b0;
            count_a_reset_o <= 1'b0;
        end else begin
            adc_trigger_o   <= hit && (mode_r == MODE_CMP_TRIG) && adc_enabled_i;
            count_a_reset_o <= trig_pend_r && tick_r && match;
            if (hit && (mode_r == MODE_CMP_TRIG)) begin
                trig_pend_r <= 1'b1;
            end else if (!match || tick_r) begin
                trig_pend_r <= 1'b0;
            end
        end
    end

    // ========================================================================
    // PWM
    // ========================================================================
    // duty LSBs are shadowed at the period boundary for glitch-free edges
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            duty_latch_r <= DUTY_RST;
            pwm_r        <= 1'b0;
        end else if (!is_pwm) begin
            pwm_r        <= 1'b0;
        end else if (period_match_i) begin
            duty_latch_r <= duty_lsb_r;
            pwm_r        <= ({val_lo_r, duty_lsb_r} != 10'h000);
        end else if (pwm_base_i == {val_hi_r, duty_latch_r}) begin
            pwm_r        <= 1'b0;
        end
    end

    // ========================================================================
    // pin drive
    // ========================================================================
    // registered, so the pin follows the latch one cycle later
    always_ff @(posedge clock_i) begin
        if (reset_i || wr_zero) begin
            pin_out_o <= 1'b0;
            pin_oe_o  <= 1'b0;
        end else begin
            pin_out_o <= is_pwm ? pwm_r : cmp_latch_r;
            pin_oe_o  <= pin_owned;
        end
    end

    // ========================================================================
    // event flag
    // ========================================================================
    // write one to clear; a new event in the same cycle wins
    assign flag_clr = wr_i && (addr_i == ADR_FLAG) && wdata_i[FLAG_BIT];

    always_comb begin
        flag_nxt = flag_r;
        if (flag_clr) begin
            flag_nxt = 1'b0;
        end
        if (cap_fire || hit) begin
            flag_nxt = 1'b1;
        end
    end

    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            flag_r            <= 1'b0;
            unit_event_flag_o <= 1'b0;
        end else begin
            flag_r            <= flag_nxt;
            unit_event_flag_o <= flag_nxt;
        end
    end

    // ========================================================================
    // read port
    // ========================================================================
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            rdata_o <= REG_RST;
        end else if (rd_i) begin
            rdata_o <= REG_RST;
            case (addr_i)
                ADR_CTRL: begin
                    rdata_o[CTRL_MODE_MSB:CTRL_MODE_LSB] <= mode_r;
                    rdata_o[CTRL_DUTY_MSB:CTRL_DUTY_LSB] <= duty_lsb_r;
                end
                ADR_VAL_LO: rdata_o <= val_lo_r;
                ADR_VAL_HI: rdata_o <= val_hi_r;
                ADR_FLAG:   rdata_o[FLAG_BIT] <= flag_r;
                ADR_STATUS: begin
                    rdata_o[ST_MATCH_BIT] <= match_r;
                    rdata_o[ST_PEND_BIT]  <= trig_pend_r;
                    rdata_o[ST_PINO_BIT]  <= pin_out_o;
                    rdata_o[ST_PINI_BIT]  <= pin_in_i;
                end
                default:    rdata_o <= REG_RST;
            endcase
        end else begin
            rdata_o <= REG_RST;
        end
    end

    // ========================================================================
    // checks
    // ========================================================================
    a_capture_copy: assert property (@(posedge clock_i) disable iff (reset_i)
        cap_fire |=> ({val_hi_r, val_lo_r} == $past(count_a_r)) && flag_r)
        else $error("capture did not copy count");

    a_flag_sticky: assert property (@(posedge clock_i) disable iff (reset_i)
        flag_r && !flag_clr |=> flag_r)
        else $error("event flag dropped by itself");

    a_cmp_flag: assert property (@(posedge clock_i) disable iff (reset_i)
        hit |=> flag_r ##1 unit_event_flag_o)
        else $error("compare match lost its flag");

    a_cmp_set_pin: assert property (@(posedge clock_i) disable iff (reset_i)
        hit && (mode_r == MODE_CMP_SET) && !wr_ctrl |=> cmp_latch_r ##1 (pin_out_o || !pin_oe_o))
        else $error("set on match not seen on pin");

    a_swevt_no_pin: assert property (@(posedge clock_i) disable iff (reset_i)
        (mode_r == MODE_CMP_SWEVT) [*2] |-> !pin_oe_o)
        else $error("software event mode drives pin");

    a_trig_immediate: assert property (@(posedge clock_i) disable iff (reset_i)
        hit && (mode_r == MODE_CMP_TRIG) && adc_enabled_i |=> adc_trigger_o)
        else $error("trigger late");

    a_trig_cancel: assert property (@(posedge clock_i) disable iff (reset_i)
        !match |=> !count_a_reset_o)
        else $error("counter reset without match");

    a_zero_latch: assert property (@(posedge clock_i) disable iff (reset_i)
        wr_zero |=> !cmp_latch_r && !pin_oe_o)
        else $error("zero write left latch or pin");

    a_pwm_release: assert property (@(posedge clock_i) disable iff (reset_i)
        is_pwm && wr_zero |=> !pin_oe_o ##1 !pin_oe_o)
        else $error("pin still held after PWM off");

    a_sleep_cmp: assert property (@(posedge clock_i) disable iff (reset_i)
        sleep_i && !wr_zero |=> $stable(cmp_latch_r) && !adc_trigger_o)
        else $error("compare active in sleep");

endmodule // ccu_unit

/* File: testbench/ccu_partner.sv */
`timescale 1ns/1ps
// ============================================================
// counter A and the pin source on the far side of the unit
module ccu_partner (
    input  wire logic        clock_i,
    input  wire logic        run_i,
    input  wire logic        load_i,
    input  wire logic [15:0] load_val_i,
    input  wire logic        reset_req_i,
    input  wire logic        level_i,
    input  wire logic        pin_out_i,
    input  wire logic        pin_oe_i,
    output logic             pin_o,
    output logic      [15:0] count_o,
    output logic             tick_o
);
    logic [1:0] div_r;
    logic       pend_r;
    // the pin reads what the unit drives, else the outside level
    assign pin_o = pin_oe_i ? pin_out_i : level_i;
    // synchronous tick every fourth cycle, never the raw system clock; idle while run_i is low
    always_ff @(posedge clock_i) begin
        div_r  <= run_i ? div_r + 2'h1 : 2'h0;
        tick_o <= run_i && (div_r == 2'h3);
    end
    // a reset request waits for the next counter edge and raises no overflow
    always_ff @(posedge clock_i) begin
        if (load_i) begin
            count_o <= load_val_i;
            pend_r  <= 1'b0;
        end else if (tick_o) begin
            count_o <= pend_r ? 16'h0000 : count_o + 16'h0001;
            pend_r  <= 1'b0;
        end else if (reset_req_i) begin
            pend_r <= 1'b1;
        end
    end
endmodule // ccu_partner

/* File: testbench/test_capture_compare_unit.sv */
`timescale 1ns/1ps
module test_capture_compare_unit;
    import ccu_pkg::*;
    logic              clock_i = 0, reset_i = 1, wr_i = 0, rd_i = 0, rd_d = 0;
    logic [ADDR_W-1:0] addr_i = 0;
    logic [DATA_W-1:0] wdata_i = 0, rdata_o, exp_q[$];
    logic              pin_w, pin_out_o, pin_oe_o, tick, rst_o, trig, flag_o;
    logic              level = 0, run = 0, load = 1, sleep = 0, ext = 0, adc_en = 1, pmatch = 0;
    logic [9:0]        pwm_base = 0;
    logic [15:0]       count, load_val = 0, seed = 16'h5512;
    int                errors = 0, comparisons = 0;
    ccu_unit dut_u (.clock_i(clock_i), .reset_i(reset_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .pin_in_i(pin_w), .pin_out_o(pin_out_o),
        .pin_oe_o(pin_oe_o), .count_a_i(count), .count_a_tick_i(tick), .count_a_ext_i(ext),
        .count_a_reset_o(rst_o), .adc_enabled_i(adc_en), .adc_trigger_o(trig),
        .pwm_base_i(pwm_base), .period_match_i(pmatch), .sleep_i(sleep),
        .unit_event_flag_o(flag_o));
    ccu_partner far_u (.clock_i(clock_i), .run_i(run), .load_i(load), .load_val_i(load_val),
        .reset_req_i(rst_o), .level_i(level), .pin_out_i(pin_out_o), .pin_oe_i(pin_oe_o),
        .pin_o(pin_w), .count_o(count), .tick_o(tick));
    // ============================================================
    // clock, helpers and bus tasks
    initial forever #20 clock_i = ~clock_i;
    function automatic logic [15:0] rnd();
        seed ^= seed << 7;
        seed ^= seed >> 9;
        seed ^= seed << 8;
        return seed;
    endfunction
    task automatic chk(string name, logic [15:0] exp, logic [15:0] got);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic wr(logic [ADDR_W-1:0] a, logic [DATA_W-1:0] d);
        @(posedge clock_i);
        addr_i <= a; wdata_i <= d; wr_i <= 1'b1;
        @(posedge clock_i);
        wr_i <= 1'b0;
    endtask
    task automatic rd(logic [ADDR_W-1:0] a, logic [DATA_W-1:0] e);
        @(posedge clock_i);
        addr_i <= a; rd_i <= 1'b1; exp_q.push_back(e);
        @(posedge clock_i);
        rd_i <= 1'b0;
    endtask
    task automatic pulse();
        @(posedge clock_i); level <= 1'b1;
        repeat (3) @(posedge clock_i); level <= 1'b0;
        repeat (3) @(posedge clock_i);
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // read data is only valid in the cycle after the strobe, so look mid-cycle
    always @(posedge clock_i) rd_d <= rd_i;
    always @(negedge clock_i) begin
        if (rd_d === 1'b1) begin
            if (exp_q.size() == 0) chk("read queue", 16'h0001, 16'h0000);
            else chk("rdata_o", exp_q.pop_front(), rdata_o);
        end
    end
    // ============================================================
    // main sequence
    initial begin : main
        logic [3:0]  cm[4] = '{MODE_CAP_FALL, MODE_CAP_RISE, MODE_CAP_RISE4, MODE_CAP_RISE16};
        int          cn[4] = '{1, 1, 4, 16};
        logic [3:0]  pm[4] = '{MODE_CMP_SET, MODE_CMP_CLR, MODE_CMP_TOGGLE, MODE_CMP_SWEVT};
        logic [1:0]  pe[4] = '{2'h3, 2'h2, 2'h3, 2'h0};
        logic [15:0] v;
        int          n;
        repeat (2) @(posedge clock_i);
        reset_i <= 1'b0;
        load    <= 1'b0;
        rd(ADR_CTRL, REG_RST);
        wr(3'h5, 8'hFF);
        rd(3'h5, 8'h00);
        $display("test registers done");
        for (int i = 0; i < 4; i++) begin
            v = rnd();
            @(posedge clock_i); load_val <= v; load <= 1'b1;
            @(posedge clock_i); load <= 1'b0;
            wr(ADR_CTRL, {4'h0, cm[i]});
            wr(ADR_FLAG, 8'h01);
            for (int k = 0; k < cn[i]; k++) begin
                if (k == cn[i] - 1) rd(ADR_FLAG, 8'h00);
                pulse();
            end
            chk("unit_event_flag_o", 16'h0001, flag_o);
            rd(ADR_VAL_LO, v[7:0]);
            rd(ADR_VAL_HI, v[15:8]);
            wr(ADR_CTRL, CTRL_ZERO);
            wr(ADR_FLAG, 8'h01);
        end
        $display("test capture done");
        wr(ADR_VAL_LO, v[7:0]);
        wr(ADR_VAL_HI, v[15:8]);
        for (int i = 0; i < 4; i++) begin
            wr(ADR_CTRL, {4'h0, pm[i]});
            repeat (4) @(posedge clock_i);
            chk("pin oe,out", pe[i], {pin_oe_o, pin_out_o});
            chk("unit_event_flag_o", 16'h0001, flag_o);
            wr(ADR_CTRL, CTRL_ZERO);
            repeat (2) @(posedge clock_i);
            chk("pin after off", 16'h0000, {pin_oe_o, pin_out_o});
            wr(ADR_FLAG, 8'h01);
        end
        $display("test compare done");
        @(posedge clock_i); load_val <= v - 16'h0006; load <= 1'b1; run <= 1'b1;
        @(posedge clock_i); load <= 1'b0;
        wr(ADR_CTRL, {4'h0, MODE_CMP_TRIG});
        for (n = 0; n < 100 && trig !== 1'b1; n++) @(negedge clock_i);
        chk("adc_trigger_o", 16'h0001, trig);
        for (n = 0; n < 12 && rst_o !== 1'b1; n++) @(negedge clock_i);
        chk("count_a_reset_o", 16'h0001, rst_o);
        repeat (6) @(posedge clock_i);
        chk("count after reset", 16'h0001, count < 16'h0002);
        chk("pin_oe_o", 16'h0000, pin_oe_o);
        // converter disabled: the counter reset still follows, the trigger never does
        @(posedge clock_i); adc_en <= 1'b0; load_val <= v - 16'h0006; load <= 1'b1;
        @(posedge clock_i); load <= 1'b0;
        for (n = 0; n < 60 && rst_o !== 1'b1; n++) begin
            @(negedge clock_i);
            chk("adc_trigger_o off", 16'h0000, trig);
        end
        chk("count_a_reset_o", 16'h0001, rst_o);
        $display("test trigger done");
        // sleep: capture only with an external counter clock, compare held off
        wr(ADR_CTRL, CTRL_ZERO);
        @(posedge clock_i); load_val <= v; load <= 1'b1; run <= 1'b0; sleep <= 1'b1;
        @(posedge clock_i); load <= 1'b0;
        wr(ADR_FLAG, 8'h01);
        wr(ADR_CTRL, {4'h0, MODE_CAP_RISE});
        pulse();
        chk("flag in sleep", 16'h0000, flag_o);
        ext <= 1'b1;
        pulse();
        chk("flag ext sleep", 16'h0001, flag_o);
        rd(ADR_VAL_LO, v[7:0]);
        ext <= 1'b0;
        wr(ADR_CTRL, CTRL_ZERO);
        wr(ADR_FLAG, 8'h01);
        wr(ADR_CTRL, {4'h0, MODE_CMP_SET});
        repeat (4) @(negedge clock_i);
        chk("pin in sleep", 16'h0002, {pin_oe_o, pin_out_o});
        chk("flag cmp sleep", 16'h0000, flag_o);
        @(posedge clock_i); sleep <= 1'b0;
        repeat (4) @(negedge clock_i);
        chk("pin after wake", 16'h0003, {pin_oe_o, pin_out_o});
        $display("test sleep done");
        // standard PWM: duty 0x00E, period boundary sets the pin, time base clears it
        wr(ADR_CTRL, CTRL_ZERO);
        wr(ADR_VAL_LO, 8'h03);
        wr(ADR_CTRL, {2'h0, 2'h2, MODE_PWM_TOP, 2'h0});
        @(posedge clock_i); pmatch <= 1'b1;
        @(posedge clock_i); pmatch <= 1'b0;
        repeat (2) @(negedge clock_i);
        chk("pwm start", 16'h0003, {pin_oe_o, pin_out_o});
        wr(ADR_VAL_HI, 8'h55);
        rd(ADR_VAL_HI, 8'h03);
        @(posedge clock_i); pwm_base <= 10'h00E;
        repeat (3) @(negedge clock_i);
        chk("pwm end", 16'h0002, {pin_oe_o, pin_out_o});
        wr(ADR_CTRL, CTRL_ZERO);
        @(negedge clock_i);
        chk("pwm off", 16'h0000, {pin_oe_o, pin_out_o});
        $display("test pwm done");
        end_sim();
    end
endmodule // test_capture_compare_unit
